/* File: design/eas_pkg.sv */
// Shared constants and encodings for the event/action sequencer.
package eas_pkg;
    // Pair table limits; the count port is clamped into this range.
    localparam int unsigned PAIRS_MIN = 1;
    localparam int unsigned PAIRS_MAX = 20;
    localparam int unsigned CNT_W     = 5;
    // Core clock period and scan interval, both in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned SCAN_TIME_NS  = 1000000;
    // Longest scan that fits the interval, so the count rounds down.
    localparam int unsigned SCAN_CYC = SCAN_TIME_NS / CLK_PERIOD_NS;
    // Comparator operator codes.
    localparam logic [1:0] CMP_LT = 2'h0;
    localparam logic [1:0] CMP_EQ = 2'h1;
    localparam logic [1:0] CMP_GT = 2'h2;
    localparam logic [1:0] CMP_NE = 2'h3;
    // Logic rule operator codes, applied left to right.
    localparam logic [1:0] LOP_AND     = 2'h0;
    localparam logic [1:0] LOP_OR      = 2'h1;
    localparam logic [1:0] LOP_AND_NOT = 2'h2;
    localparam logic [1:0] LOP_OR_NOT  = 2'h3;
    // Scan phases, Gray coded along the loop.
    typedef enum logic [1:0] {
        PH_IDLE  = 2'h0,
        PH_CMP   = 2'h1,
        PH_LOGIC = 2'h3,
        PH_EVAL  = 2'h2
    } eas_phase_e;
endpackage

/* File: design/eas_sequencer.sv */
// Event/action sequencer with comparators and three-input logic rules.
//
// Contract
// RULE1: Action runs only when its event is true.
// RULE2: Event is status, logic rule or comparator.
// RULE3: Pairs share an index, advance ascending.
// RULE4: Only the current index event is evaluated.
// RULE5: False event: no action, index held.
// RULE6: Start sets index zero, retries each scan.
// RULE7: Pair count configurable from one to twenty.
// RULE8: After last pair, index wraps to zero.
// RULE9: Comparator checks a variable against a preset.
// RULE10: Logic rule combines three inputs, AND/OR/NOT.
// RULE11: Comparators and rules run without the sequencer.
// RULE12: Comparators and rules update before event evaluation.
`timescale 1ns/1ps
module eas_sequencer #(
    parameter int unsigned SCAN_CYCLES = eas_pkg::SCAN_CYC,
    parameter int unsigned NUM_STATUS  = 8,
    parameter int unsigned NUM_DIN     = 4,
    parameter int unsigned NUM_CMP     = 4,
    parameter int unsigned NUM_RULES   = 4,
    parameter int unsigned NUM_VAR     = 4,
    parameter int unsigned DATA_W      = 16,
    parameter int unsigned ACT_W       = 8,
    localparam int unsigned SRC_W = NUM_STATUS + NUM_DIN + NUM_CMP + NUM_RULES,
    localparam int unsigned SEL_W = $clog2(SRC_W),
    localparam int unsigned VSEL_W = (NUM_VAR > 1) ? $clog2(NUM_VAR) : 1
) (
    // Clock and reset.
    input  wire logic                               core_clk,
    input  wire logic                               rst,
    // Sequencer control.
    input  wire logic                               seq_start,
    input  wire logic                               seq_stop,
    input  wire logic [eas_pkg::CNT_W-1:0]          pair_count,
    input  wire logic [eas_pkg::PAIRS_MAX*SEL_W-1:0] event_sel_flat,
    input  wire logic [eas_pkg::PAIRS_MAX*ACT_W-1:0] action_flat,
    // Condition sources.
    input  wire logic [NUM_STATUS-1:0]              status_in,
    input  wire logic [NUM_DIN-1:0]                 din_pin,
    input  wire logic [NUM_VAR*DATA_W-1:0]          var_in_flat,
    // Comparator settings.
    input  wire logic [NUM_CMP*VSEL_W-1:0]          cmp_var_sel_flat,
    input  wire logic [NUM_CMP*2-1:0]               cmp_op_flat,
    input  wire logic [NUM_CMP*DATA_W-1:0]          cmp_preset_flat,
    // Logic rule settings.
    input  wire logic [NUM_RULES*3*SEL_W-1:0]       rule_sel_flat,
    input  wire logic [NUM_RULES*4-1:0]             rule_op_flat,
    // Results.
    output logic                                    seq_running,
    output logic [eas_pkg::CNT_W-1:0]               seq_index,
    output logic                                    action_stb,
    output logic [ACT_W-1:0]                        action_code,
    output logic [NUM_CMP-1:0]                      cmp_out,
    output logic [NUM_RULES-1:0]                    rule_out
);
    import eas_pkg::*;

    // Clamp the programmed count into the legal pair range.
    function automatic logic [CNT_W-1:0] eas_clamp(input logic [CNT_W-1:0] n);
        if (n < CNT_W'(PAIRS_MIN)) begin
            return CNT_W'(PAIRS_MIN);
        end else if (n > CNT_W'(PAIRS_MAX)) begin
            return CNT_W'(PAIRS_MAX);
        end else begin
            return n;
        end
    endfunction
    // Apply one logic operator; the NOT forms invert the right operand.
    function automatic logic eas_lop(input logic a, input logic b,
                                     input logic [1:0] op);
        case (op)
            LOP_AND:     return a & b;
            LOP_OR:      return a | b;
            LOP_AND_NOT: return a & ~b;
            LOP_OR_NOT:  return a | ~b;
            default:     return 1'b0;
        endcase
    endfunction
    // Scan divider, phase and sequencer state.
    logic [31:0]             scan_cnt_reg;    // Cycles into the scan.
    logic [31:0]             scan_cnt_next;
    eas_phase_e              phase_reg;       // Position within a scan.
    eas_phase_e              phase_next;
    logic                    running_reg;     // Sequencer active.
    logic                    running_next;
    logic [CNT_W-1:0]        index_reg;       // Current pair.
    logic [CNT_W-1:0]        index_next;
    logic                    stb_reg;         // Action strobe.
    logic                    stb_next;
    logic [ACT_W-1:0]        code_reg;        // Last action code.
    logic [ACT_W-1:0]        code_next;
    logic [NUM_CMP-1:0]      cmp_out_reg;     // Registered comparators.
    logic [NUM_CMP-1:0]      cmp_out_next;
    logic [NUM_RULES-1:0]    rule_out_reg;    // Registered logic rules.
    logic [NUM_RULES-1:0]    rule_out_next;
    logic [NUM_DIN-1:0]      din_meta_reg;    // First synchroniser stage.
    logic [NUM_DIN-1:0]      din_sync_reg;    // Second synchroniser stage.
    logic                    scan_tick;       // One pulse per scan.
    logic [NUM_CMP-1:0]      cmp_res;         // Live comparator results.
    logic [NUM_RULES-1:0]    rule_res;        // Live logic rule results.
    logic [SRC_W-1:0]        src;             // All Boolean sources.
    logic [SEL_W-1:0]        ev_sel;          // Source of current event.
    logic                    ev_true;         // Current event condition.
    logic [CNT_W-1:0]        last_idx;        // Index of the last pair.

    // Digital input pins are asynchronous, so they pass two flops.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            din_meta_reg <= '0;
            din_sync_reg <= '0;
        end else begin
            din_meta_reg <= din_pin;
            din_sync_reg <= din_meta_reg;
        end
    end
    // Boolean source vector: status, inputs, comparators, then rules.
    // Rules read last scan's rule outputs, so chains settle one scan late.
    assign src = {rule_out_reg, cmp_out_reg, din_sync_reg, status_in};
    assign scan_tick = (scan_cnt_reg == 32'(SCAN_CYCLES - 1));
    assign last_idx = eas_clamp(pair_count) - 1'b1;

    // RULE9 preset comparators
    for (genvar c = 0; c < NUM_CMP; c++) begin : g_cmp
        logic [VSEL_W-1:0] vsel;
        logic [DATA_W-1:0] val;
        logic [DATA_W-1:0] preset;
        assign vsel   = cmp_var_sel_flat[c*VSEL_W +: VSEL_W];
        assign val    = var_in_flat[vsel*DATA_W +: DATA_W];
        assign preset = cmp_preset_flat[c*DATA_W +: DATA_W];
        always_comb begin
            case (cmp_op_flat[c*2 +: 2])
                CMP_LT:  cmp_res[c] = (val < preset);
                CMP_EQ:  cmp_res[c] = (val == preset);
                CMP_GT:  cmp_res[c] = (val > preset);
                default: cmp_res[c] = (val != preset);
            endcase
        end
    end
    // RULE10 three-input rules
    for (genvar r = 0; r < NUM_RULES; r++) begin : g_rule
        logic [3*SEL_W-1:0] sel;
        logic [3:0]         op;
        assign sel = rule_sel_flat[r*3*SEL_W +: 3*SEL_W];
        assign op  = rule_op_flat[r*4 +: 4];
        assign rule_res[r] = eas_lop(eas_lop(src[sel[0 +: SEL_W]],
                                             src[sel[SEL_W +: SEL_W]],
                                             op[1:0]),
                                     src[sel[2*SEL_W +: SEL_W]], op[3:2]);
    end
    // RULE2 event source select
    assign ev_sel  = event_sel_flat[index_reg*SEL_W +: SEL_W];
    assign ev_true = src[ev_sel];

    // Next-state logic for the scan, operands and sequencer.
    always_comb begin
        scan_cnt_next = scan_tick ? '0 : scan_cnt_reg + 32'h1;
        phase_next    = phase_reg;
        running_next  = running_reg;
        index_next    = index_reg;
        stb_next      = 1'b0;
        code_next     = code_reg;
        cmp_out_next  = cmp_out_reg;
        rule_out_next = rule_out_reg;
        case (phase_reg)
            PH_IDLE: begin
                if (scan_tick) begin
                    phase_next = PH_CMP;
                end
            end
            // RULE12 comparators first
            PH_CMP: begin
                // RULE11 free-running comparators
                cmp_out_next = cmp_res;
                phase_next   = PH_LOGIC;
            end
            PH_LOGIC: begin
                // RULE11 free-running rules
                rule_out_next = rule_res;
                phase_next    = PH_EVAL;
            end
            PH_EVAL: begin
                phase_next = PH_IDLE;
                // RULE4 single event evaluated
                if (running_reg && ev_true) begin
                    // RULE1 action on true
                    stb_next  = 1'b1;
                    code_next = action_flat[index_reg*ACT_W +: ACT_W];
                    // RULE8 wrap after last
                    if (index_reg >= last_idx) begin
                        index_next = '0;
                    end else begin
                        // RULE3 ascending pair index
                        index_next = index_reg + 1'b1;
                    end
                end
                // RULE5 false holds index
            end
            default: begin
                phase_next = PH_IDLE;
            end
        endcase
        // RULE6 start from zero
        if (seq_start) begin
            running_next = 1'b1;
            index_next   = '0;
            stb_next     = 1'b0;
        end else if (seq_stop) begin
            running_next = 1'b0;
            stb_next     = 1'b0;
        end
        // RULE7 clamp to count
        if (index_next > last_idx) begin
            index_next = '0;
        end
    end

    // State registers only.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scan_cnt_reg <= '0;
            phase_reg    <= PH_IDLE;
            running_reg  <= 1'b0;
            index_reg    <= '0;
            stb_reg      <= 1'b0;
            code_reg     <= '0;
            cmp_out_reg  <= '0;
            rule_out_reg <= '0;
        end else begin
            scan_cnt_reg <= scan_cnt_next;
            phase_reg    <= phase_next;
            running_reg  <= running_next;
            index_reg    <= index_next;
            stb_reg      <= stb_next;
            code_reg     <= code_next;
            cmp_out_reg  <= cmp_out_next;
            rule_out_reg <= rule_out_next;
        end
    end
    // Outputs are straight from flops.
    assign seq_running = running_reg;
    assign seq_index   = index_reg;
    assign action_stb  = stb_reg;
    assign action_code = code_reg;
    assign cmp_out     = cmp_out_reg;
    assign rule_out    = rule_out_reg;

    // Checks on the sequencing behaviour.
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    evt_gate_a: assert property ( // RULE1
        stb_reg |-> $past(ev_true) && $past(running_reg))
        else $error("action strobe without a true event");
    src_sel_a: assert property ( // RULE2
        stb_reg |-> $past(src[event_sel_flat[index_reg*SEL_W +: SEL_W]])
        && code_reg == $past(action_flat[index_reg*ACT_W +: ACT_W]))
        else $error("event taken from the wrong source");
    step_index_a: assert property ( // RULE3
        (phase_reg == PH_EVAL && running_reg && ev_true && !seq_start
         && !seq_stop && index_reg < last_idx && $stable(pair_count))
        |=> index_reg == $past(index_reg) + 1'b1)
        else $error("index did not advance by one");
    one_eval_a: assert property ( // RULE4
        stb_reg |-> $past(phase_reg) == PH_EVAL ##1 !stb_reg [*3])
        else $error("more than one evaluation in a scan");
    hold_index_a: assert property ( // RULE5
        (phase_reg == PH_EVAL && running_reg && !ev_true && !seq_start
         && !seq_stop && $stable(pair_count))
        |=> $stable(index_reg) && !stb_reg)
        else $error("false event changed index or acted");
    start_zero_a: assert property ( // RULE6
        seq_start |=> index_reg == '0 && running_reg && !stb_reg)
        else $error("start did not select pair zero");
    count_range_a: assert property ( // RULE7
        index_reg <= last_idx || $changed(pair_count))
        else $error("index beyond programmed pair count");
    wrap_zero_a: assert property ( // RULE8
        (phase_reg == PH_EVAL && running_reg && ev_true && !seq_start
         && !seq_stop && index_reg == last_idx) |=> index_reg == '0)
        else $error("index did not wrap after last pair");
    cmp_value_a: assert property ( // RULE9
        phase_reg == PH_CMP |=> cmp_out_reg == $past(cmp_res))
        else $error("comparator result not captured");
    rule_free_a: assert property ( // RULE11
        phase_reg == PH_LOGIC |=> rule_out_reg == $past(rule_res))
        else $error("logic rule result not captured");
    scan_order_a: assert property ( // RULE12
        phase_reg == PH_EVAL |-> $past(phase_reg, 1) == PH_LOGIC
        && $past(phase_reg, 2) == PH_CMP)
        else $error("event evaluated before operands updated");
    wrap_seen_c: cover property (
        stb_reg && index_reg == '0 && last_idx != '0);
    stall_seen_c: cover property (
        phase_reg == PH_EVAL && running_reg && !ev_true);
    restart_c: cover property (running_reg && index_reg != '0 && seq_start);
endmodule // eas_sequencer

/* File: dv/eas_sequencer_tb.sv */
// Self-checking testbench for the event/action sequencer.
`timescale 1ns/1ps
module eas_sequencer_tb;
    import eas_pkg::*;
    // Stimulus driven at the falling clock edge.
    logic         core_clk;
    logic         rst;
    logic         seq_start;
    logic         seq_stop;
    logic [4:0]   pair_count;
    logic [99:0]  event_sel_flat;
    logic [159:0] action_flat;
    logic [7:0]   status_in;
    logic [3:0]   din_pin;
    logic [63:0]  var_in_flat;
    logic [7:0]   cmp_var_sel_flat;
    logic [7:0]   cmp_op_flat;
    logic [63:0]  cmp_preset_flat;
    logic [59:0]  rule_sel_flat;
    logic [15:0]  rule_op_flat;
    // Observed results.
    logic         seq_running;
    logic [4:0]   seq_index;
    logic         action_stb;
    logic [7:0]   action_code;
    logic [3:0]   cmp_out;
    logic [3:0]   rule_out;
    int           bad_count;
    int           check_count;
    int           i;

    // A scan of eight cycles keeps the run short; all waits except the time limit count clock cycles.
    eas_sequencer #(.SCAN_CYCLES(8)) dut (
        .core_clk(core_clk), .rst(rst), .seq_start(seq_start),
        .seq_stop(seq_stop), .pair_count(pair_count),
        .event_sel_flat(event_sel_flat), .action_flat(action_flat),
        .status_in(status_in), .din_pin(din_pin),
        .var_in_flat(var_in_flat), .cmp_var_sel_flat(cmp_var_sel_flat),
        .cmp_op_flat(cmp_op_flat), .cmp_preset_flat(cmp_preset_flat),
        .rule_sel_flat(rule_sel_flat), .rule_op_flat(rule_op_flat),
        .seq_running(seq_running), .seq_index(seq_index),
        .action_stb(action_stb), .action_code(action_code),
        .cmp_out(cmp_out), .rule_out(rule_out)
    );

    // Free-running 50 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Counts a comparison and reports a mismatch; x never matches.
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits a bounded time for one strobe, then checks code and index.
    task automatic expect_act(input logic [7:0] code, input logic [4:0] idx);
        int n;
        n = 0;
        @(negedge core_clk);
        while (action_stb !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        chk("action_stb", 8'h01, {7'h0, action_stb});
        chk("action_code", code, action_code);
        chk("seq_index", {3'h0, idx}, {3'h0, seq_index});
    endtask

    // Watches n cycles and expects no strobe at all.
    task automatic expect_quiet(input int n);
        int seen;
        seen = 0;
        repeat (n) begin
            @(negedge core_clk);
            if (action_stb !== 1'b0) seen++;
        end
        chk("strobe count", 8'h00, seen[7:0]);
    endtask

    // Prints the verdict and ends the run.
    task automatic end_of_test;
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole test is about 50 scans; the limit leaves a wide margin.
    initial begin
        #50000;
        bad_count++;
        end_of_test();
    end

    // Main sequence.
    initial begin
        bad_count = 0;
        check_count = 0;
        rst = 1'b1;
        seq_start = 1'b0;
        seq_stop = 1'b0;
        pair_count = 5'h03;
        // Pair 1 waits on comparator 0, pair 2 on rule 0, rest on status 0.
        event_sel_flat = '0;
        event_sel_flat[5+:5] = 5'h0c;
        event_sel_flat[10+:5] = 5'h10;
        for (i = 0; i < 20; i++) action_flat[i*8+:8] = 8'ha0 + i[7:0];
        status_in = 8'h0a;
        din_pin = 4'h0;
        var_in_flat = {16'h0003, 16'h0007, 16'h0005, 16'h0064};
        cmp_var_sel_flat = 8'he4;
        cmp_op_flat = {CMP_NE, CMP_EQ, CMP_LT, CMP_GT};
        cmp_preset_flat = {16'h0003, 16'h0007, 16'h0009, 16'h0032};
        rule_sel_flat = {5'h3, 5'h2, 5'h1, 5'h3, 5'h2, 5'h1,
                         5'h3, 5'h2, 5'h1, 5'h0f, 5'h0c, 5'h01};
        rule_op_flat = {LOP_AND, LOP_OR_NOT, LOP_OR_NOT, LOP_AND_NOT,
                        LOP_AND_NOT, LOP_OR, LOP_OR, LOP_AND};
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        chk("seq_running", 8'h00, {7'h0, seq_running});
        chk("seq_index", 8'h00, {3'h0, seq_index});
        // Comparators and rules update while the sequencer is stopped.
        repeat (24) @(negedge core_clk);
        chk("cmp_out", 8'h07, {4'h0, cmp_out});
        chk("rule_out", 8'h0d, {4'h0, rule_out});
        // Boundary values: equal is neither less nor greater.
        var_in_flat = {16'h0004, 16'h0008, 16'h0009, 16'h0032};
        status_in = 8'h04;
        repeat (24) @(negedge core_clk);
        chk("cmp_out", 8'h08, {4'h0, cmp_out});
        chk("rule_out", 8'h07, {4'h0, rule_out});
        var_in_flat = {16'h0003, 16'h0007, 16'h0005, 16'h0064};
        status_in = 8'h0a;
        repeat (24) @(negedge core_clk);
        chk("seq_running", 8'h00, {7'h0, seq_running});
        seq_start = 1'b1;
        @(negedge core_clk);
        seq_start = 1'b0;
        chk("seq_running", 8'h01, {7'h0, seq_running});
        chk("seq_index", 8'h00, {3'h0, seq_index});
        expect_quiet(24);
        status_in[0] = 1'b1;
        expect_act(8'ha0, 5'h01);
        expect_act(8'ha1, 5'h02);
        expect_act(8'ha2, 5'h00);
        status_in[0] = 1'b0;
        expect_quiet(24);
        chk("seq_index", 8'h00, {3'h0, seq_index});
        // A count of zero is taken as one pair.
        pair_count = 5'h00;
        status_in[0] = 1'b1;
        expect_act(8'ha0, 5'h00);
        expect_act(8'ha0, 5'h00);
        // Counts above twenty are taken as twenty.
        pair_count = 5'h1f;
        for (i = 0; i < 20; i++) begin
            expect_act(8'ha0 + i[7:0], 5'((i + 1) % 20));
        end
        expect_act(8'ha0, 5'h01);
        seq_stop = 1'b1;
        @(negedge core_clk);
        seq_stop = 1'b0;
        chk("seq_running", 8'h00, {7'h0, seq_running});
        expect_quiet(24);
        chk("seq_index", 8'h01, {3'h0, seq_index});
        seq_start = 1'b1;
        @(negedge core_clk);
        seq_start = 1'b0;
        chk("seq_index", 8'h00, {3'h0, seq_index});
        expect_act(8'ha0, 5'h01);
        // Pair 1 now waits on digital input 0, seen through the synchroniser.
        event_sel_flat[5+:5] = 5'h08;
        expect_quiet(24);
        chk("seq_index", 8'h01, {3'h0, seq_index});
        din_pin = 4'h1;
        expect_act(8'ha1, 5'h02);
        end_of_test();
    end
endmodule // eas_sequencer_tb
